// >>> rtl/lic_illum_ctrl.sv
// Illumination control: photo feedback drive, shunts, LED select and per-colour settings
// Operation
// - Two modes, continuous and pulsed, chosen by a control bit.
// - Continuous mode: light below reference raises buck drive enable.
// - Light above reference drops drive enable at once; repeats while enabled.
// - Pulsed mode: crossing the reference ends the current light pulse.
// - A 12-bit reference is provided for the comparator in both modes.
// - A 10-bit peak current setting bounds external inductor current.
// - Sync output overrides buck off time; drive enable switches buck.
// - Gain picks one of 14 steps plus a per-colour trim code.
// - Settings held per colour; active colour's set is applied.
// - Between pulses inductor current flows through the shunt paths.
// - An LED select output is only on while that colour is driven.
// - A sample timer triggers timed conversions during a colour slice.
// - Higher gain step gives lower light for the same reference.
// - Output capacitance select low in continuous, high in pulsed mode.
// - Short shunt holds until peak current reached, then the LED is enabled.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "lic_regs.svh"
module lic_illum_ctrl #(
  parameter int SMP_W = 16
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [`LIC_ADDR_W-1:0] reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  input  wire lic_pkg::lic_slice_t    slice_in,
  input  wire logic                   photo_cmp_in,
  input  wire logic                   peak_current_reached_in,
  output logic                        buck_drive_enable,
  output logic                        buck_sync,
  output logic                        short_shunt_gate,
  output logic                        dissipative_shunt_gate,
  output logic      [2:0]             led_select,
  output logic                        output_cap_select,
  output logic      [11:0]            ref_dac_code,
  output logic      [9:0]             peak_current_setting,
  output logic      [3:0]             photo_amp_gain,
  output logic      [2:0]             photo_amp_trim,
  output logic                        adc_sample_trigger
);
  // Refused at elaboration: the read path packs the period into one 32-bit word
  if (SMP_W < 8 || SMP_W > 32)
  begin : g_bad_smp_w
    $error("lic_illum_ctrl SMP_W out of range");
  end

  // Slice signals come from another device, so they are synchronised with the comparator
  logic [8:0] sync_raw;
  logic [8:0] sync_q;
  assign sync_raw = {slice_in, photo_cmp_in, peak_current_reached_in};
  lic_sync #(.WIDTH(9)) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in (sync_raw),
    .sync_out (sync_q)
  );
  lic_pkg::lic_slice_t slice_s;
  logic                light_below_s;
  logic                peak_reached_s;
  assign slice_s        = sync_q[8:2];
  assign light_below_s  = sync_q[1];
  assign peak_reached_s = sync_q[0];

  function automatic lic_pkg::lic_colour_t decode_colour(input logic [3:0] sel);
    lic_pkg::lic_colour_t c;
    c = lic_pkg::LIC_COL_NONE;
    unique case (sel)
      4'h1:    c = lic_pkg::LIC_COL_RED;
      4'h2:    c = lic_pkg::LIC_COL_GREEN;
      4'h4:    c = lic_pkg::LIC_COL_BLUE;
      default: c = lic_pkg::LIC_COL_NONE;
    endcase
    return c;
  endfunction

  // Register file
  logic                     mode_pulsed_ff;
  logic                     smp_en_ff;
  lic_pkg::lic_colour_cfg_t cfg_ff [3];
  logic [SMP_W-1:0]         smp_per_ff;
  logic [31:0]              rdata_ff;
  logic                     nxt_mode_pulsed;
  logic                     nxt_smp_en;
  lic_pkg::lic_colour_cfg_t nxt_cfg [3];
  logic [SMP_W-1:0]         nxt_smp_per;
  logic [31:0]              nxt_rdata;
  logic [31:0]              status_word;

  always_comb
  begin
    nxt_mode_pulsed = mode_pulsed_ff;
    nxt_smp_en      = smp_en_ff;
    nxt_cfg         = cfg_ff;
    nxt_smp_per     = smp_per_ff;
    nxt_rdata       = 32'h0000_0000;
    if (reg_wr)
    begin
      unique case (reg_addr)
        `LIC_OFF_CTRL:
        begin
          nxt_mode_pulsed = reg_wdata[`LIC_CTRL_MODE_BIT];
          nxt_smp_en      = reg_wdata[`LIC_CTRL_SMP_BIT];
        end
        `LIC_OFF_REF_R:  nxt_cfg[0].ref_code = reg_wdata[11:0];
        `LIC_OFF_REF_G:  nxt_cfg[1].ref_code = reg_wdata[11:0];
        `LIC_OFF_REF_B:  nxt_cfg[2].ref_code = reg_wdata[11:0];
        `LIC_OFF_PEAK_CURRENT_SETTING_R: nxt_cfg[0].peak_current_setting = reg_wdata[9:0];
        `LIC_OFF_PEAK_CURRENT_SETTING_G: nxt_cfg[1].peak_current_setting = reg_wdata[9:0];
        `LIC_OFF_PEAK_CURRENT_SETTING_B: nxt_cfg[2].peak_current_setting = reg_wdata[9:0];
        `LIC_OFF_GAIN_R, `LIC_OFF_GAIN_G, `LIC_OFF_GAIN_B:
        begin
          // Step codes past the last gain step are clamped to it
          for (int i = 0; i < 3; i++)
          begin
            if (reg_addr == `LIC_OFF_GAIN_R + 4'(i))
            begin
              nxt_cfg[i].gain_step = (reg_wdata[3:0] > 4'(`LIC_GAIN_STEPS - 1)) ?
                                     4'(`LIC_GAIN_STEPS - 1) : reg_wdata[3:0];
              nxt_cfg[i].gain_trim = reg_wdata[6:4];
            end
          end
        end
        `LIC_OFF_SMP_PER: nxt_smp_per = reg_wdata[SMP_W-1:0];
        default: ;
      endcase
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        `LIC_OFF_CTRL:    nxt_rdata = {30'h0, smp_en_ff, mode_pulsed_ff};
        `LIC_OFF_REF_R:   nxt_rdata = {20'h0, cfg_ff[0].ref_code};
        `LIC_OFF_REF_G:   nxt_rdata = {20'h0, cfg_ff[1].ref_code};
        `LIC_OFF_REF_B:   nxt_rdata = {20'h0, cfg_ff[2].ref_code};
        `LIC_OFF_PEAK_CURRENT_SETTING_R:  nxt_rdata = {22'h0, cfg_ff[0].peak_current_setting};
        `LIC_OFF_PEAK_CURRENT_SETTING_G:  nxt_rdata = {22'h0, cfg_ff[1].peak_current_setting};
        `LIC_OFF_PEAK_CURRENT_SETTING_B:  nxt_rdata = {22'h0, cfg_ff[2].peak_current_setting};
        `LIC_OFF_GAIN_R:  nxt_rdata = {25'h0, cfg_ff[0].gain_trim, cfg_ff[0].gain_step};
        `LIC_OFF_GAIN_G:  nxt_rdata = {25'h0, cfg_ff[1].gain_trim, cfg_ff[1].gain_step};
        `LIC_OFF_GAIN_B:  nxt_rdata = {25'h0, cfg_ff[2].gain_trim, cfg_ff[2].gain_step};
        `LIC_OFF_STATUS:  nxt_rdata = status_word;
        `LIC_OFF_SMP_PER: nxt_rdata = 32'(smp_per_ff);
        default:          nxt_rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_pulsed_ff <= 1'b0;
      smp_en_ff      <= 1'b0;
      for (int i = 0; i < 3; i++)
      begin
        cfg_ff[i] <= '{`LIC_REF_RST, `LIC_PEAK_CURRENT_SETTING_RST, `LIC_GAIN_RST, `LIC_TRIM_RST};
      end
      smp_per_ff <= SMP_W'(`LIC_SMP_PER_RST);
      rdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      mode_pulsed_ff <= nxt_mode_pulsed;
      smp_en_ff      <= nxt_smp_en;
      cfg_ff         <= nxt_cfg;
      smp_per_ff     <= nxt_smp_per;
      rdata_ff       <= nxt_rdata;
    end
  end
  assign reg_rdata = rdata_ff;

  // Loop control
  lic_pkg::lic_colour_t colour;
  logic [1:0]           cidx;
  logic                 pulse_done_ff;
  logic                 led_on_ff;
  logic                 drive_ff;
  logic                 sync_ff;
  logic                 short_ff;
  logic                 diss_ff;
  logic [2:0]           sel_ff;
  logic                 cap_ff;
  logic                 nxt_pulse_done;
  logic                 nxt_led_on;
  logic                 nxt_drive;
  logic                 nxt_sync_out;
  logic                 nxt_short;
  logic                 nxt_diss;
  logic [2:0]           nxt_sel;
  logic                 blanking;

  assign colour   = decode_colour(slice_s.led_colour_select);
  assign cidx     = (colour == lic_pkg::LIC_COL_GREEN) ? 2'd1 :
                    (colour == lic_pkg::LIC_COL_BLUE)  ? 2'd2 : 2'd0;
  assign blanking = slice_s.short_shunt_gate || slice_s.dissipative_shunt_gate;

  always_comb
  begin
    nxt_short      = slice_s.short_shunt_gate && !peak_reached_s;
    nxt_diss       = slice_s.dissipative_shunt_gate;
    // LED stays off until the short shunt phase has charged the inductor
    nxt_led_on     = (colour != lic_pkg::LIC_COL_NONE) && slice_s.drive_gate && !nxt_short
                     && !slice_s.dissipative_shunt_gate;
    nxt_sel        = 3'h0;
    if (nxt_led_on)
    begin
      nxt_sel[cidx] = 1'b1;
    end
    nxt_pulse_done = pulse_done_ff;
    if (!nxt_led_on)
    begin
      nxt_pulse_done = 1'b0;
    end
    else if (mode_pulsed_ff && !light_below_s)
    begin
      nxt_pulse_done = 1'b1;
    end
    if (!slice_s.drive_gate)
    begin
      nxt_drive = 1'b0;
    end
    else if (blanking)
    begin
      nxt_drive = slice_s.short_shunt_gate && !peak_reached_s;
    end
    else if (mode_pulsed_ff)
    begin
      nxt_drive = light_below_s && !pulse_done_ff && nxt_led_on;
    end
    else
    begin
      nxt_drive = light_below_s && nxt_led_on;
    end
    // Sync cuts the buck off time short whenever a fresh turn-on is wanted
    nxt_sync_out = nxt_drive && !drive_ff;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pulse_done_ff <= 1'b0;
      led_on_ff     <= 1'b0;
      drive_ff      <= 1'b0;
      sync_ff       <= 1'b0;
      short_ff      <= 1'b0;
      diss_ff       <= 1'b0;
      sel_ff        <= 3'h0;
      cap_ff        <= 1'b0;
    end
    else
    begin
      pulse_done_ff <= nxt_pulse_done;
      led_on_ff     <= nxt_led_on;
      drive_ff      <= nxt_drive;
      sync_ff       <= nxt_sync_out;
      short_ff      <= nxt_short;
      diss_ff       <= nxt_diss;
      sel_ff        <= nxt_sel;
      cap_ff        <= mode_pulsed_ff;
    end
  end

  assign buck_drive_enable      = drive_ff;
  assign buck_sync              = sync_ff;
  assign short_shunt_gate       = short_ff;
  assign dissipative_shunt_gate = diss_ff;
  assign led_select             = sel_ff;
  assign output_cap_select      = cap_ff;
  assign ref_dac_code           = cfg_ff[cidx].ref_code;
  assign peak_current_setting   = cfg_ff[cidx].peak_current_setting;
  assign photo_amp_gain         = cfg_ff[cidx].gain_step;
  assign photo_amp_trim         = cfg_ff[cidx].gain_trim;
  assign status_word = {25'h0, sel_ff, short_ff, diss_ff, sync_ff, drive_ff};

  // Sample timer: periodic triggers while an LED is lit
  logic [SMP_W-1:0] smp_cnt_ff;
  logic             trig_ff;
  logic [SMP_W-1:0] nxt_smp_cnt;
  logic             nxt_trig;
  always_comb
  begin
    nxt_smp_cnt = smp_cnt_ff;
    nxt_trig    = 1'b0;
    if (!smp_en_ff || !led_on_ff)
    begin
      nxt_smp_cnt = '0;
    end
    else if (smp_cnt_ff >= smp_per_ff)
    begin
      nxt_smp_cnt = '0;
      nxt_trig    = 1'b1;
    end
    else
    begin
      nxt_smp_cnt = smp_cnt_ff + SMP_W'(1);
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      smp_cnt_ff <= '0;
      trig_ff    <= 1'b0;
    end
    else
    begin
      smp_cnt_ff <= nxt_smp_cnt;
      trig_ff    <= nxt_trig;
    end
  end
  assign adc_sample_trigger = trig_ff;

  a_drive_needs_gate: assert property (@(posedge clk) disable iff (rst)
    !$past(slice_s.drive_gate) |-> !buck_drive_enable)
    else $error("drive enable high without drive gate");
  a_cm_drive_follows: assert property (@(posedge clk) disable iff (rst)
    (!mode_pulsed_ff && slice_s.drive_gate && !blanking && nxt_led_on && light_below_s)
    |=> buck_drive_enable)
    else $error("drive enable missed light below reference");
  a_cm_drive_drops: assert property (@(posedge clk) disable iff (rst)
    (!mode_pulsed_ff && !blanking && !light_below_s) |=> !buck_drive_enable)
    else $error("drive enable not dropped above reference");
  sequence s_pulse_ended;
    mode_pulsed_ff && nxt_led_on && !light_below_s;
  endsequence
  a_dm_pulse_end: assert property (@(posedge clk) disable iff (rst)
    s_pulse_ended ##1 (nxt_led_on && mode_pulsed_ff) |=> !buck_drive_enable)
    else $error("pulse not ended at peak threshold");
  a_cap_select: assert property (@(posedge clk) disable iff (rst)
    output_cap_select == $past(mode_pulsed_ff))
    else $error("output capacitance select wrong for mode");
  a_one_led: assert property (@(posedge clk) disable iff (rst)
    $onehot0(led_select))
    else $error("more than one LED selected");
  a_led_off_shunt: assert property (@(posedge clk) disable iff (rst)
    short_shunt_gate |-> led_select == 3'h0)
    else $error("LED on during short shunt charge");
  a_short_ends: assert property (@(posedge clk) disable iff (rst)
    peak_reached_s |=> !short_shunt_gate)
    else $error("short shunt kept after peak current");
  a_reset_quiet: assert property (@(posedge clk)
    $past(rst) |-> (!buck_drive_enable && !short_shunt_gate && led_select == 3'h0))
    else $error("outputs active after reset");
endmodule // lic_illum_ctrl
`default_nettype wire

// >>> rtl/lic_pkg.sv
// Types shared by the illumination control block
package lic_pkg;
  typedef enum logic [1:0] {
    LIC_COL_NONE,
    LIC_COL_RED,
    LIC_COL_GREEN,
    LIC_COL_BLUE
  } lic_colour_t;
  typedef struct packed {
    logic [3:0] led_colour_select;
    logic       drive_gate;
    logic       short_shunt_gate;
    logic       dissipative_shunt_gate;
  } lic_slice_t;
  typedef struct packed {
    logic [11:0] ref_code;
    logic [9:0]  peak_current_setting;
    logic [3:0]  gain_step;
    logic [2:0]  gain_trim;
  } lic_colour_cfg_t;
endpackage

// >>> rtl/lic_regs.svh
// Register offsets, field positions, reset values and timing counts of the illumination control
`ifndef LIC_REGS_SVH
`define LIC_REGS_SVH
`define LIC_ADDR_W        4
`define LIC_OFF_CTRL      4'h0
`define LIC_OFF_REF_R     4'h1
`define LIC_OFF_REF_G     4'h2
`define LIC_OFF_REF_B     4'h3
`define LIC_OFF_PEAK_CURRENT_SETTING_R    4'h4
`define LIC_OFF_PEAK_CURRENT_SETTING_G    4'h5
`define LIC_OFF_PEAK_CURRENT_SETTING_B    4'h6
`define LIC_OFF_GAIN_R    4'h7
`define LIC_OFF_GAIN_G    4'h8
`define LIC_OFF_GAIN_B    4'h9
`define LIC_OFF_STATUS    4'hA
`define LIC_OFF_SMP_PER   4'hB
`define LIC_CTRL_MODE_BIT 0
`define LIC_CTRL_SMP_BIT  1
`define LIC_REF_RST       12'h800
`define LIC_PEAK_CURRENT_SETTING_RST      10'h200
`define LIC_GAIN_RST      4'h0
`define LIC_TRIM_RST      3'h0
`define LIC_GAIN_STEPS    14
`define LIC_SMP_PER_RST   16'h00FA
`endif

// >>> rtl/lic_sync.sv
// Two-flop synchroniser for asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module lic_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;
  logic [WIDTH-1:0] nxt_meta;
  logic [WIDTH-1:0] nxt_sync;
  // Refused at elaboration, before any logic is built
  if (WIDTH < 1)
  begin : g_bad_width
    $error("lic_sync WIDTH must be positive");
  end
  always_comb
  begin
    nxt_meta = async_in;
    nxt_sync = meta_ff;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else
    begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end
  assign sync_out = sync_ff;
endmodule // lic_sync
`default_nettype wire

// >>> sim/lic_disp_model.sv
// Display controller model: plays one colour bit slice with both blanking phases
`timescale 1ns/1ps
`default_nettype none
module lic_disp_model (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                start,
  input  wire logic [3:0]          colour,
  input  wire logic [7:0]          on_len,
  output var  lic_pkg::lic_slice_t slice_out,
  output logic                     busy
);
  // Phases: 0 idle, 1 dissipative shunt, 2 short shunt, 3 LED lit
  logic [1:0] phase_ff;
  logic [7:0] cnt_ff;
  assign busy = (phase_ff != 2'h0);
  // Idle colour is zero, never a stale code, so no LED can be chosen by accident
  always_comb
  begin
    slice_out                        = '0;
    slice_out.dissipative_shunt_gate = (phase_ff == 2'h1);
    slice_out.short_shunt_gate       = (phase_ff == 2'h2);
    slice_out.drive_gate             = phase_ff[1];
    slice_out.led_colour_select      = (phase_ff == 2'h3) ? colour : 4'h0;
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      phase_ff <= 2'h0;
      cnt_ff   <= 8'h00;
    end
    else if (phase_ff == 2'h0)
    begin
      phase_ff <= start ? 2'h1 : 2'h0;
      cnt_ff   <= 8'h03;
    end
    else if (cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
    else
    begin
      phase_ff <= phase_ff + 2'h1;
      cnt_ff   <= (phase_ff == 2'h1) ? 8'h05 : on_len - 8'h01;
    end
  end
endmodule // lic_disp_model
`default_nettype wire

// >>> sim/test_lic_illum_ctrl.sv
// Self-checking bench for the illumination control block
`timescale 1ns/1ps
`default_nettype none
`include "lic_regs.svh"
module test_lic_illum_ctrl;
  logic                clk;
  logic                rst;
  logic [3:0]          reg_addr;
  logic [31:0]         reg_wdata;
  logic                reg_wr;
  logic                reg_rd;
  logic [31:0]         reg_rdata;
  lic_pkg::lic_slice_t slice_in;
  logic                photo_cmp_in;
  logic                peak;
  logic                buck_drive_enable;
  logic                buck_sync;
  logic                short_shunt_gate;
  logic                dissipative_shunt_gate;
  logic [2:0]          led_select;
  logic                output_cap_select;
  logic [11:0]         ref_dac_code;
  logic [9:0]          peak_current_setting;
  logic [3:0]          photo_amp_gain;
  logic [2:0]          photo_amp_trim;
  logic                adc_sample_trigger;
  logic                start;
  logic [3:0]          colour;
  logic [7:0]          on_len;
  logic                busy;
  logic [11:0]         ref_m [3];
  logic [9:0]          peak_current_setting_m [3];
  logic [6:0]          gain_m [3];
  logic [31:0]         d;
  int                  failures;
  int                  check_count;
  int                  cycles;

  lic_illum_ctrl i_dut (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .slice_in(slice_in), .photo_cmp_in(photo_cmp_in),
    .peak_current_reached_in(peak), .buck_drive_enable(buck_drive_enable),
    .buck_sync(buck_sync), .short_shunt_gate(short_shunt_gate),
    .dissipative_shunt_gate(dissipative_shunt_gate), .led_select(led_select),
    .output_cap_select(output_cap_select), .ref_dac_code(ref_dac_code),
    .peak_current_setting(peak_current_setting), .photo_amp_gain(photo_amp_gain),
    .photo_amp_trim(photo_amp_trim), .adc_sample_trigger(adc_sample_trigger)
  );
  lic_disp_model i_model (
    .clk(clk), .rst(rst), .start(start), .colour(colour), .on_len(on_len),
    .slice_out(slice_in), .busy(busy)
  );

  always #2 clk = ~clk;

  task automatic finish_test();
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // A hang in any wait loop ends here instead of running forever
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      failures++;
      finish_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    @(negedge clk);
    v = reg_rdata;
    @(posedge clk);
  endtask

  // Two synchroniser flops plus the output register: three edges from pin to output
  task automatic follow();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask

  function automatic logic ph(input int p);
    case (p)
      0: return slice_in.dissipative_shunt_gate === 1'b1;
      1: return slice_in.short_shunt_gate === 1'b1;
      2: return slice_in.led_colour_select !== 4'h0;
      default: return busy === 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] exp_trig(input logic pulsed, input int n);
    return 32'(pulsed ? (n >= 4 && n <= 6) : (n == 0));
  endfunction

  task automatic wait_phase(input int p);
    for (int k = 0; k < 40 && !ph(p); k++)
      @(negedge clk);
    chk(32'(ph(p)), 32'h1);
    follow();
  endtask

  task automatic run_slice(input int i, input logic pulsed);
    int n;
    @(posedge clk);
    colour <= 4'(1 << i);
    on_len <= 8'h40;
    peak   <= 1'b0;
    start  <= 1'b1;
    @(posedge clk);
    start  <= 1'b0;
    wait_phase(0);
    chk(32'({dissipative_shunt_gate, short_shunt_gate, led_select, buck_drive_enable}),
        32'h20);
    wait_phase(1);
    chk(32'({dissipative_shunt_gate, short_shunt_gate, led_select, buck_drive_enable}),
        32'h11);
    @(posedge clk);
    peak <= 1'b1;
    follow();
    chk(32'({short_shunt_gate, led_select}), 32'h0);
    wait_phase(2);
    chk(32'({led_select, buck_drive_enable}), 32'({3'(1 << i), 1'b1}));
    chk(32'(ref_dac_code), 32'(ref_m[i]));
    chk(32'(peak_current_setting), 32'(peak_current_setting_m[i]));
    chk(32'({photo_amp_trim, photo_amp_gain}), 32'(gain_m[i]));
    @(posedge clk);
    rd(4'hA, d);
    chk(d, 32'({3'(1 << i), 4'h1}));
    @(posedge clk);
    photo_cmp_in <= 1'b0;
    follow();
    chk(32'(buck_drive_enable), 32'h0);
    @(posedge clk);
    photo_cmp_in <= 1'b1;
    follow();
    chk(32'({buck_drive_enable, buck_sync}), pulsed ? 32'h0 : 32'h3);
    @(negedge clk);
    chk(32'(buck_sync), 32'h0);
    n = 0;
    repeat (30)
    begin
      @(negedge clk);
      n += int'(adc_sample_trigger === 1'b1);
    end
    chk(exp_trig(pulsed, n), 32'h1);
    wait_phase(3);
    chk(32'({buck_drive_enable, led_select, short_shunt_gate}), 32'h0);
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {reg_addr, reg_wdata, reg_wr, reg_rd, peak, start, colour, on_len} = '0;
    photo_cmp_in = 1'b1;
    void'($urandom(32'hD84C));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(32'({buck_drive_enable, buck_sync, short_shunt_gate, dissipative_shunt_gate,
             led_select, output_cap_select, adc_sample_trigger}), 32'h0);
    chk(32'({ref_dac_code, peak_current_setting}), 32'({`LIC_REF_RST, `LIC_PEAK_CURRENT_SETTING_RST}));
    @(posedge clk);
    for (int i = 0; i < 3; i++)
    begin
      ref_m[i]  = 12'($urandom());
      peak_current_setting_m[i] = 10'($urandom());
      gain_m[i] = {3'($urandom()), 4'($urandom_range(13))};
    end
    // Full-scale reference and the top gain step as corner values
    ref_m[0]  = 12'hFFF;
    gain_m[2] = 7'h7D;
    for (int i = 0; i < 3; i++)
    begin
      wr(4'(i + 1), 32'(ref_m[i]));
      wr(4'(i + 4), 32'(peak_current_setting_m[i]));
      wr(4'(i + 7), 32'(gain_m[i]));
      rd(4'(i + 1), d);
      chk(d, 32'(ref_m[i]));
      rd(4'(i + 4), d);
      chk(d, 32'(peak_current_setting_m[i]));
      rd(4'(i + 7), d);
      chk(d, 32'(gain_m[i]));
    end
    // A step code past the last gain step must read back clamped
    wr(4'h7, 32'h0000_007F);
    gain_m[0] = {3'h7, 4'(`LIC_GAIN_STEPS - 1)};
    rd(4'h7, d);
    chk(d, 32'(gain_m[0]));
    rd(4'hB, d);
    chk(d, 32'(`LIC_SMP_PER_RST));
    wr(4'hC, 32'hFFFFFFFF);
    rd(4'hC, d);
    chk(d, 32'h0);
    for (int i = 0; i < 3; i++)
      run_slice(i, 1'b0);
    @(posedge clk);
    wr(4'hB, 32'h5);
    wr(4'h0, 32'h3);
    rd(4'h0, d);
    chk(d, 32'h3);
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(32'(output_cap_select), 32'h1);
    run_slice(0, 1'b1);
    run_slice(2, 1'b1);
    finish_test();
  end
endmodule // test_lic_illum_ctrl
`default_nettype wire
